// ---- cipc_pkg.sv ----
// shared constants, field layout and carrier types of the charger config registers
package cipc_pkg;

  // serial target address and register offsets
  localparam logic [6:0] TGT_ADDR    = 7'h6b;
  localparam logic [7:0] IN_SRC_OFS  = 8'h00;
  localparam logic [7:0] PWR_CFG_OFS = 8'h01;

  // input source register field positions
  localparam int IMP_BIT  = 7;
  localparam int VREG_LSB = 3;
  localparam int CAP_LSB  = 0;

  // power-on configuration register field positions
  localparam int RRST_BIT   = 7;
  localparam int WDT_BIT    = 6;
  localparam int BOOST_BIT  = 5;
  localparam int CHG_BIT    = 4;
  localparam int SYSMIN_LSB = 1;
  localparam int BLIM_BIT   = 0;

  // reset values
  localparam logic       IMP_RST  = 1'b0;
  localparam logic [3:0] VREG_RST = 4'h6;
  localparam logic [2:0] CAP_RST  = 3'h0;
  localparam logic [7:0] CFG_RST  = 8'h1b;

  // input current cap codes used as defaults
  localparam logic [2:0] CAP_100 = 3'h0;
  localparam logic [2:0] CAP_500 = 3'h2;
  localparam logic [2:0] CAP_1A  = 3'h4;
  localparam logic [2:0] CAP_2A  = 3'h6;
  localparam logic [2:0] CAP_3A  = 3'h7;

  // decode scales
  localparam logic [12:0] VIN_OFS_MV  = 13'h0f28;
  localparam logic [12:0] VIN_STEP_MV = 13'h0050;
  localparam logic [12:0] SYS_OFS_MV  = 13'h0bb8;
  localparam logic [12:0] SYS_STEP_MV = 13'h0064;
  localparam logic [11:0] BOOST_LO_MA = 12'h3e8;
  localparam logic [11:0] BOOST_HI_MA = 12'h5dc;
  localparam logic [11:0] CAP_MA [8] = '{12'h064, 12'h096, 12'h1f4, 12'h384,
                                        12'h3e8, 12'h5dc, 12'h7d0, 12'hbb8};

  // detected source kind
  typedef enum logic [1:0] {
    SRC_STD_HOST, SRC_CHG_PORT, SRC_DIV_12, SRC_DIV_3
  } cipc_src_e;

  // one register write from the serial port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cipc_wr_s;

  // strap and detection pins, synchronised together
  typedef struct packed {
    logic       psel;
    logic       boost;
    logic [2:0] ext_cap;
    cipc_src_e  src;
    logic       src_valid;
  } cipc_pins_s;

endpackage

// ---- cipc_i2c_tgt.sv ----
// two-wire serial target: address match, register pointer, multi-byte read and write
`timescale 1ns/1ps
module cipc_i2c_tgt
  import cipc_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] rd_data_in,
  output logic      [7:0] rd_addr_out,
  output cipc_wr_s        wr_out,
  output logic            sda_out,
  output logic            sda_oe_n_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA
  } cipc_tgt_e;

  cipc_tgt_e  state_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] obuf_q;
  logic       done_q;
  logic       ack_q;
  logic       scl;
  logic       sda;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;

  // both bus lines pass two flops; the idle bus is high
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // bus events seen on the synchronised lines
  assign scl   = scl_sync_q[1];
  assign sda   = sda_sync_q[1];
  assign start = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop  = scl & scl_prev_q & ~sda_prev_q & sda;
  assign rise  = scl & ~scl_prev_q;
  assign fall  = ~scl & scl_prev_q;

  // open drain: the data flop only ever drives low
  always_ff @(posedge ref_clk_in) begin
    sda_out <= 1'b0;
  end

  // byte engine; sda changes only on falling scl so start/stop stay unambiguous
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 3'h0;
      shift_q      <= 8'h00;
      obuf_q       <= 8'h00;
      done_q       <= 1'b0;
      ack_q        <= 1'b0;
      rd_addr_out  <= 8'h00;
      sda_oe_n_out <= 1'b1;
      wr_out       <= '0;
    end else begin
      wr_out.wr <= 1'b0;
      if (start) begin
        state_q      <= ST_ADDR;
        cnt_q        <= 3'h0;
        done_q       <= 1'b0;
        ack_q        <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end else if (stop) begin
        state_q      <= ST_IDLE;
        done_q       <= 1'b0;
        ack_q        <= 1'b0;
        sda_oe_n_out <= 1'b1;
      end else if (state_q != ST_IDLE && rise) begin
        if (ack_q) begin
          if (state_q == ST_RDATA && sda) begin
            state_q <= ST_IDLE; // host declined further bytes
          end
        end else begin
          shift_q <= {shift_q[6:0], sda};
          cnt_q   <= cnt_q + 3'h1;
          done_q  <= (cnt_q == 3'h7);
        end
      end else if (state_q != ST_IDLE && fall) begin
        if (done_q) begin
          done_q       <= 1'b0;
          ack_q        <= 1'b1;
          sda_oe_n_out <= 1'b1;
          case (state_q)
            ST_ADDR: begin
              if (shift_q[7:1] == TGT_ADDR) begin
                sda_oe_n_out <= 1'b0;
                state_q      <= shift_q[0] ? ST_RDATA : ST_PTR;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_PTR: begin
              if (shift_q <= PWR_CFG_OFS) begin
                sda_oe_n_out <= 1'b0;
                rd_addr_out  <= shift_q;
                state_q      <= ST_WDATA;
              end else begin
                state_q <= ST_IDLE; // undefined register: nack
              end
            end
            ST_WDATA: begin
              if (rd_addr_out <= PWR_CFG_OFS) begin
                sda_oe_n_out <= 1'b0;
                wr_out       <= '{wr: 1'b1, addr: rd_addr_out, data: shift_q};
                rd_addr_out  <= rd_addr_out + 8'h01;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            default: begin
            end
          endcase
        end else if (ack_q) begin
          ack_q        <= 1'b0;
          cnt_q        <= 3'h0;
          sda_oe_n_out <= 1'b1;
          if (state_q == ST_RDATA) begin
            obuf_q       <= rd_data_in;
            sda_oe_n_out <= rd_data_in[7];
            rd_addr_out  <= rd_addr_out + 8'h01;
          end
        end else if (state_q == ST_RDATA) begin
          sda_oe_n_out <= obuf_q[6];
          obuf_q       <= {obuf_q[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ---- cipc_regs.sv ----
// charger input source and power-on configuration register bank behind the serial port
`timescale 1ns/1ps
// Function
// - input source bit 7 puts input in high impedance; resets to 0
// - bits 6:3 give input voltage level 3.88 V plus 80 mV steps, reset 0110
// - bits 2:0 pick input current cap from 100 mA to 3 A
// - strap variant: cap resets 111, or 000/010 by boost pin when selected
// - detecting variant: cap default follows detected source type
// - config bit 7 written 1 restores defaults without leaving host mode
// - config bit 6 written 1 restarts the serial watchdog
// - config bit 5 enables boost, resets 0, and overrides charging
// - config bit 4 enables charging and resets to 1
// - bits 3:1 give minimum system voltage 3.0 V plus 0.1 V steps, reset 101
// - config register resets to 00011011; bits 5:0 are read/write, bits 7:6 are strobes and read back 0
// - any serial write moves device from default to host mode
// - target answers at address 6bh at standard or fast rate
module cipc_regs
  import cipc_pkg::*;
#(
  parameter bit ADAPTER_DETECT = 1'b0
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        source_select_pin_in,
  input  wire logic        boost_request_pin_in,
  input  wire logic [2:0]  external_current_cap_pin_in,
  input  wire logic [1:0]  source_type_in,
  input  wire logic        source_detect_done_in,
  input  wire logic        watchdog_expired_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  output logic             input_disconnected_state_out,
  output logic      [12:0] vin_reg_mv_out,
  output logic      [11:0] input_cap_ma_out,
  output logic      [12:0] min_sys_mv_out,
  output logic             charging_enable_out,
  output logic             boost_output_enable_out,
  output logic      [11:0] boost_cap_ma_out,
  output logic             watchdog_restart_out,
  output logic             host_mode_out
);

  cipc_pins_s pin_meta_q;
  cipc_pins_s pin_sync_q;
  logic       src_valid_prev_q;
  cipc_wr_s   wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] rd_src;
  logic [7:0] rd_cfg;
  logic       wr00;
  logic       wr01;
  logic       detect_rise;
  logic [2:0] dflt_code;
  logic [2:0] eff_code;

  // register state
  logic       imp_q;
  logic [3:0] vreg_code_q;
  logic [2:0] cap_code_q;
  logic       boost_q;
  logic       chg_q;
  logic [2:0] sysmin_q;
  logic       blim_q;
  logic       host_mode_q;
  logic       load_pend_q;
  logic       soft_rst_q;
  logic       wdt_q;

  cipc_i2c_tgt u_tgt (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .rd_data_in   (rd_data),
    .rd_addr_out  (rd_addr),
    .wr_out       (wr),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out)
  );

  // pins are analog-side levels: two flops before any use; these flops run
  // through reset so the straps are settled when the default cap loads at release
  always_ff @(posedge ref_clk_in) begin
    pin_meta_q <= '{psel: source_select_pin_in,
                    boost: boost_request_pin_in,
                    ext_cap: external_current_cap_pin_in,
                    src: cipc_src_e'(source_type_in),
                    src_valid: source_detect_done_in};
    pin_sync_q <= pin_meta_q;
  end

  // detect edge flop; an edge right at release only repeats the default load
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      src_valid_prev_q <= 1'b0;
    end else begin
      src_valid_prev_q <= pin_sync_q.src_valid;
    end
  end

  assign detect_rise = pin_sync_q.src_valid & ~src_valid_prev_q;
  assign wr00        = wr.wr && wr.addr == IN_SRC_OFS;
  assign wr01        = wr.wr && wr.addr == PWR_CFG_OFS;

  // default input cap from straps or from the detected source
  always_comb begin
    dflt_code = CAP_3A;
    if (!ADAPTER_DETECT) begin
      if (pin_sync_q.psel) begin
        dflt_code = pin_sync_q.boost ? CAP_500 : CAP_100;
      end
    end else begin
      case (pin_sync_q.src)
        SRC_CHG_PORT: dflt_code = CAP_3A;
        SRC_DIV_12:   dflt_code = CAP_2A;
        SRC_DIV_3:    dflt_code = CAP_1A;
        default:      dflt_code = pin_sync_q.boost ? CAP_500 : CAP_100;
      endcase
    end
  end

  // default cap is loaded after reset release, since straps may not sit still in reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= soft_rst_q
                   | (ADAPTER_DETECT && detect_rise && !host_mode_q);
    end
  end

  // input source register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || soft_rst_q) begin
      imp_q       <= IMP_RST;
      vreg_code_q <= VREG_RST;
      cap_code_q  <= CAP_RST;
    end else if (wr00) begin
      imp_q       <= wr.data[IMP_BIT];
      vreg_code_q <= wr.data[VREG_LSB +: 4];
      cap_code_q  <= wr.data[CAP_LSB +: 3];
    end else if (load_pend_q) begin
      cap_code_q  <= dflt_code;
    end
  end

  // power-on configuration register; bits 7 and 6 are strobes, never stored
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || soft_rst_q) begin
      boost_q  <= CFG_RST[BOOST_BIT];
      chg_q    <= CFG_RST[CHG_BIT];
      sysmin_q <= CFG_RST[SYSMIN_LSB +: 3];
      blim_q   <= CFG_RST[BLIM_BIT];
    end else if (wr01) begin
      boost_q  <= wr.data[BOOST_BIT];
      chg_q    <= wr.data[CHG_BIT];
      sysmin_q <= wr.data[SYSMIN_LSB +: 3];
      blim_q   <= wr.data[BLIM_BIT];
    end
  end

  // one-shot strobes: a one lasts a single cycle and then reads back as zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      soft_rst_q <= 1'b0;
      wdt_q      <= 1'b0;
    end else begin
      soft_rst_q <= wr01 & wr.data[RRST_BIT];
      wdt_q      <= wr01 & wr.data[WDT_BIT];
    end
  end

  // host mode: a write sets it and wins over a coincident watchdog expiry;
  // register reset leaves it alone on purpose
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      host_mode_q <= 1'b0;
    end else if (wr.wr) begin
      host_mode_q <= 1'b1;
    end else if (watchdog_expired_in) begin
      host_mode_q <= 1'b0;
    end
  end

  // read-back images
  assign rd_src = {imp_q, vreg_code_q, cap_code_q};
  assign rd_cfg = {2'b00, boost_q, chg_q, sysmin_q, blim_q};

  always_comb begin
    if (rd_addr == IN_SRC_OFS) begin
      rd_data = rd_src;
    end else if (rd_addr == PWR_CFG_OFS) begin
      rd_data = rd_cfg;
    end else begin
      rd_data = 8'h00; // multi-read past the last register
    end
  end

  // the pin cap and register cap share one monotonic code scale
  assign eff_code = (cap_code_q < pin_sync_q.ext_cap) ? cap_code_q
                                                      : pin_sync_q.ext_cap;

  // decoded settings to the analog side, all registered
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      input_disconnected_state_out <= 1'b0;
      vin_reg_mv_out               <= VIN_OFS_MV;
      input_cap_ma_out             <= CAP_MA[0];
      min_sys_mv_out               <= SYS_OFS_MV;
      charging_enable_out          <= 1'b0;
      boost_output_enable_out      <= 1'b0;
      boost_cap_ma_out             <= BOOST_LO_MA;
      watchdog_restart_out         <= 1'b0;
      host_mode_out                <= 1'b0;
    end else begin
      input_disconnected_state_out <= imp_q;
      vin_reg_mv_out   <= VIN_OFS_MV + VIN_STEP_MV * 13'(vreg_code_q);
      input_cap_ma_out <= CAP_MA[eff_code];
      min_sys_mv_out   <= SYS_OFS_MV + SYS_STEP_MV * 13'(sysmin_q);
      // boost wins so a bad host setting never runs both converters
      charging_enable_out     <= chg_q & ~boost_q;
      boost_output_enable_out <= boost_q;
      boost_cap_ma_out        <= blim_q ? BOOST_HI_MA : BOOST_LO_MA;
      watchdog_restart_out    <= wdt_q;
      host_mode_out           <= host_mode_q;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_imp_reset : assert property (
    $past(rst_in) |-> !imp_q && vreg_code_q == VREG_RST)
    else $error("input source reset value wrong");

  chk_vin_decode : assert property (
    wr00 ##1 !soft_rst_q |=>
      vin_reg_mv_out == VIN_OFS_MV + VIN_STEP_MV * 13'($past(wr.data[6:3], 2)))
    else $error("input voltage level not decoded from write");

  chk_cap_min : assert property (
    eff_code <= cap_code_q && eff_code <= pin_sync_q.ext_cap
    && (eff_code == cap_code_q || eff_code == pin_sync_q.ext_cap))
    else $error("effective input cap is not the lower one");

  chk_cap_decode : assert property (
    1'b1 |=> input_cap_ma_out == CAP_MA[$past(eff_code)])
    else $error("input cap current does not match code");

  chk_default_cap : assert property (
    load_pend_q && !wr00 |=> cap_code_q == $past(dflt_code))
    else $error("default input cap not loaded");

  chk_strap_table : assert property (
    !ADAPTER_DETECT && !pin_sync_q.psel |-> dflt_code == CAP_3A)
    else $error("strap default cap wrong");

  chk_strap_select : assert property (
    !ADAPTER_DETECT && pin_sync_q.psel |-> dflt_code == {1'b0, pin_sync_q.boost, 1'b0})
    else $error("strap default cap wrong with source select high");

  chk_soft_reset : assert property (
    wr01 && wr.data[RRST_BIT] |-> ##2 rd_cfg == CFG_RST && host_mode_q)
    else $error("register reset failed or left host mode");

  chk_wdt_pulse : assert property (
    wr01 && wr.data[WDT_BIT] |-> ##2 watchdog_restart_out ##1 !watchdog_restart_out)
    else $error("watchdog restart strobe wrong");

  chk_boost_over : assert property (
    boost_output_enable_out |-> !charging_enable_out)
    else $error("charging enabled during boost");

  chk_cfg_reset : assert property (
    $past(rst_in) |-> rd_cfg == CFG_RST)
    else $error("configuration reset value wrong");

  chk_min_sys : assert property (
    wr01 && !wr.data[RRST_BIT] |-> ##2
      min_sys_mv_out == SYS_OFS_MV + SYS_STEP_MV * 13'($past(wr.data[3:1], 2)))
    else $error("minimum system voltage not decoded");

  chk_host_mode : assert property (
    wr.wr |=> host_mode_q)
    else $error("write did not enter host mode");

  cov_src_write : cover property (wr00 ##[1:20] soft_rst_q);
  cov_boost_on  : cover property (wr01 ##2 boost_output_enable_out);
  cov_wdt_kick  : cover property (watchdog_restart_out);
  cov_reload    : cover property (load_pend_q && !host_mode_q ##1 !load_pend_q);

endmodule

// ---- cipc_host_model.sv ----
// host-side two-wire bus model: start, stop, bytes and register transfers
`timescale 1ns/1ps
module cipc_host_model
  import cipc_pkg::*;
#(
  parameter int HALF = 12
)
(
  input  wire logic clk_in,
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // bus idles released; the clock line stands high between frames
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // whole cycles only, so every line change lands just after an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // data moves only while the clock line is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic seen);
    wt(HALF / 2);
    sda_low_out <= ~b;
    wt(HALF / 2);
    scl_out <= 1'b1;
    wt(HALF / 2);
    seen = sda_line_in;
    wt(HALF / 2);
    scl_out <= 1'b0;
  endtask

  // serves as repeated start too, since it releases data first
  task automatic start();
    wt(HALF / 2);
    sda_low_out <= 1'b0;
    wt(HALF / 2);
    scl_out <= 1'b1;
    wt(HALF);
    sda_low_out <= 1'b1;
    wt(HALF);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    wt(HALF / 2);
    sda_low_out <= 1'b1;
    wt(HALF / 2);
    scl_out <= 1'b1;
    wt(HALF);
    sda_low_out <= 1'b0;
    wt(HALF);
  endtask

  // eight bits msb first, then the ninth bit; last=1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(data, 1'b1, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // host answers the single data byte with a nack, ending the read
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    xfer({TGT_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    start();
    xfer({TGT_ADDR, 1'b1}, 1'b1, rx, a2);
    xfer(8'hff, 1'b1, data, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ---- cipc_regs_test.sv ----
// self-checking bench for the charger input source and configuration registers
`timescale 1ns/1ps
module cipc_regs_test
  import cipc_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        source_select_pin_in = 1'b0;
  logic        boost_request_pin_in = 1'b0;
  logic [2:0]  external_current_cap_pin_in = 3'h7;
  logic        watchdog_expired_in = 1'b0;
  logic        scl_in;
  logic        sda_in;
  logic        host_sda_low;
  logic        sda_out;
  logic        sda_oe_n_out;
  logic        input_disconnected_state_out;
  logic [12:0] vin_reg_mv_out;
  logic [11:0] input_cap_ma_out;
  logic [12:0] min_sys_mv_out;
  logic        charging_enable_out;
  logic        boost_output_enable_out;
  logic [11:0] boost_cap_ma_out;
  logic        watchdog_restart_out;
  logic        host_mode_out;
  logic [1:0]  det_type = 2'h0;
  logic        det_done = 1'b0;
  logic [11:0] det_cap_ma;
  logic [7:0]  cur0;
  logic [15:0] cap_tbl [8] = '{16'h0064, 16'h0096, 16'h01f4, 16'h0384,
                              16'h03e8, 16'h05dc, 16'h07d0, 16'h0bb8};
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          kicks = 0;

  // open-drain data line with pull-up: low if either party pulls it
  assign sda_in = ~host_sda_low & (sda_oe_n_out | sda_out);

  always #4 ref_clk_in = ~ref_clk_in;

  cipc_regs DUT (.ref_clk_in, .rst_in, .scl_in, .sda_in, .source_select_pin_in,
                 .boost_request_pin_in, .external_current_cap_pin_in,
                 .source_type_in(2'h0), .source_detect_done_in(1'b0), .watchdog_expired_in,
                 .sda_out, .sda_oe_n_out, .input_disconnected_state_out, .vin_reg_mv_out,
                 .input_cap_ma_out, .min_sys_mv_out, .charging_enable_out,
                 .boost_output_enable_out, .boost_cap_ma_out, .watchdog_restart_out,
                 .host_mode_out);

  cipc_host_model host (.clk_in(ref_clk_in), .sda_line_in(sda_in), .scl_out(scl_in),
                        .sda_low_out(host_sda_low));

  // detecting variant on an idle bus: it stays in default mode and follows detection
  cipc_regs #(.ADAPTER_DETECT(1'b1)) det_dut (.ref_clk_in, .rst_in, .scl_in(1'b1),
    .sda_in(1'b1), .source_select_pin_in, .boost_request_pin_in,
    .external_current_cap_pin_in, .source_type_in(det_type), .source_detect_done_in(det_done),
    .watchdog_expired_in, .sda_out(), .sda_oe_n_out(), .input_disconnected_state_out(),
    .vin_reg_mv_out(), .input_cap_ma_out(det_cap_ma), .min_sys_mv_out(),
    .charging_enable_out(), .boost_output_enable_out(), .boost_cap_ma_out(),
    .watchdog_restart_out(), .host_mode_out());

  // cycle ceiling guards against a hung handshake; also counts restart pulses
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (watchdog_restart_out === 1'b1) begin
      kicks <= kicks + 1;
    end
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // every decoded output worked out from the two register images
  task automatic expect_regs(input logic [7:0] r0, input logic [7:0] r1);
    logic [2:0] eff;
    eff = (r0[2:0] < external_current_cap_pin_in) ? r0[2:0] : external_current_cap_pin_in;
    check("imp", 16'(input_disconnected_state_out), 16'(r0[7]));
    check("vin_mv", 16'(vin_reg_mv_out), 16'h0f28 + 16'h0050 * 16'(r0[6:3]));
    check("cap_ma", 16'(input_cap_ma_out), cap_tbl[eff]);
    check("sysmin_mv", 16'(min_sys_mv_out), 16'h0bb8 + 16'h0064 * 16'(r1[3:1]));
    check("charge", 16'(charging_enable_out), 16'(r1[4] & ~r1[5]));
    check("boost", 16'(boost_output_enable_out), 16'(r1[5]));
    check("boost_ma", 16'(boost_cap_ma_out), r1[0] ? 16'h05dc : 16'h03e8);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    host.write_reg(TGT_ADDR, ptr, data, ok);
    check("write_ack", 16'(ok), 16'h0001);
  endtask

  task automatic expect_read(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read_reg(ptr, d, ok);
    check("read_ack", 16'(ok), 16'h0001);
    check("read_data", 16'(d), 16'(exp));
  endtask

  task automatic t_reset_defaults();
    check("host_mode", 16'(host_mode_out), 16'h0000);
    expect_regs(8'h37, 8'h1b);
    expect_read(IN_SRC_OFS, 8'h37);
    expect_read(PWR_CFG_OFS, 8'h1b);
  endtask

  // every cap code, hiz set and cleared, vin odd codes from 1 to 15
  task automatic t_input_source();
    for (int i = 0; i < 8; i++) begin
      cur0 = {i[0], 4'(2 * i + 1), 3'(i)};
      wr(IN_SRC_OFS, cur0);
      expect_regs(cur0, 8'h1b);
    end
    check("host_mode", 16'(host_mode_out), 16'h0001);
    @(posedge ref_clk_in);
    external_current_cap_pin_in <= 3'h2;
    cur0 = 8'h35;
    wr(IN_SRC_OFS, cur0);
    expect_regs(cur0, 8'h1b);
    expect_read(IN_SRC_OFS, cur0);
    @(posedge ref_clk_in);
    external_current_cap_pin_in <= 3'h7;
    host.wt(6);
    expect_regs(cur0, 8'h1b);
  endtask

  // boost and charge are never both requested by this host
  task automatic t_config();
    wr(PWR_CFG_OFS, 8'h2f);
    expect_regs(cur0, 8'h2f);
    wr(PWR_CFG_OFS, 8'h10);
    expect_regs(cur0, 8'h10);
    expect_read(PWR_CFG_OFS, 8'h10);
  endtask

  // one restart only, so spacing between restarts never arises
  task automatic t_watchdog_kick();
    int n0;
    n0 = kicks;
    wr(PWR_CFG_OFS, 8'h50);
    check("kick_pulses", 16'(kicks - n0), 16'h0001);
    expect_read(PWR_CFG_OFS, 8'h10);
  endtask

  // straps decide the cap default reloaded by a register reset
  task automatic t_soft_reset();
    @(posedge ref_clk_in);
    source_select_pin_in <= 1'b1;
    wr(IN_SRC_OFS, 8'hc1);
    wr(PWR_CFG_OFS, 8'h80);
    expect_regs(8'h30, 8'h1b);
    check("host_mode", 16'(host_mode_out), 16'h0001);
    expect_read(IN_SRC_OFS, 8'h30);
    @(posedge ref_clk_in);
    boost_request_pin_in <= 1'b1;
    wr(PWR_CFG_OFS, 8'h80);
    expect_regs(8'h32, 8'h1b);
    @(posedge ref_clk_in);
    source_select_pin_in <= 1'b0;
    wr(PWR_CFG_OFS, 8'h80);
    expect_regs(8'h37, 8'h1b);
    cur0 = 8'h37;
  endtask

  // wrong target address and undefined pointer are both refused
  task automatic t_refused();
    logic ok;
    host.write_reg(7'h6a, IN_SRC_OFS, 8'hff, ok);
    check("bad_addr_ack", 16'(ok), 16'h0000);
    host.write_reg(TGT_ADDR, 8'h02, 8'h55, ok);
    check("bad_ptr_ack", 16'(ok), 16'h0000);
    expect_regs(cur0, 8'h1b);
  endtask

  task automatic t_expiry();
    @(posedge ref_clk_in);
    watchdog_expired_in <= 1'b1;
    @(posedge ref_clk_in);
    watchdog_expired_in <= 1'b0;
    host.wt(3);
    check("host_mode", 16'(host_mode_out), 16'h0000);
    wr(IN_SRC_OFS, cur0);
    check("host_mode", 16'(host_mode_out), 16'h0001);
  endtask

  // mid-run hardware reset with the source select strap high picks the boost-pin default
  task automatic t_hw_reset();
    @(posedge ref_clk_in);
    source_select_pin_in <= 1'b1;
    boost_request_pin_in <= 1'b1;
    rst_in               <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check("host_mode", 16'(host_mode_out), 16'h0000);
    expect_regs(8'h32, 8'h1b);
    expect_read(IN_SRC_OFS, 8'h32);
  endtask

  // each detected source kind reloads its default cap on the detect edge
  task automatic t_detect();
    logic [2:0] code [4] = '{CAP_500, CAP_3A, CAP_2A, CAP_1A};
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_in);
      det_type <= 2'(k);
      det_done <= 1'b1;
      host.wt(6);
      check("det_cap_ma", 16'(det_cap_ma), cap_tbl[code[k]]);
      det_done <= 1'b0;
      host.wt(4);
    end
  endtask

  // reset held three cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    t_reset_defaults();
    t_input_source();
    t_config();
    t_watchdog_kick();
    t_soft_reset();
    t_refused();
    t_expiry();
    t_hw_reset();
    t_detect();
    report_and_stop();
  end
endmodule
